/* logic/srb_decode.sv */
`timescale 1ns/10ps
module srb_decode (
    input wire logic [srb_pkg::DESC_W-1:0] desc,
    output srb_pkg::srb_dec_t dec
);
    always_comb begin
        dec = '0;
        dec.goff = desc[srb_pkg::DESC_GOFF_LSB +: srb_pkg::GOFF_W];
        dec.il = desc[srb_pkg::DESC_IL_BIT];
        dec.pso = desc[srb_pkg::DESC_PSO_BIT];
        case (desc[srb_pkg::OP_W-1:0])
            srb_pkg::OP_ROW_WR: dec.wr = 1'b1;
            srb_pkg::OP_HALF_WR: begin
                dec.wr = 1'b1;
                dec.half = 1'b1;
            end
            srb_pkg::OP_ROW_RD: dec.rd = 1'b1;
            srb_pkg::OP_HALF_RD: begin
                dec.rd = 1'b1;
                dec.half = 1'b1;
            end
            srb_pkg::OP_ATOM_MOV: begin
                dec.atom = 1'b1;
                dec.aop = srb_pkg::AOP_MOV;
            end
            srb_pkg::OP_ATOM_INC: begin
                dec.atom = 1'b1;
                dec.aop = srb_pkg::AOP_INC;
            end
            srb_pkg::OP_ATOM_ADD: begin
                dec.atom = 1'b1;
                dec.aop = srb_pkg::AOP_ADD;
            end
            srb_pkg::OP_LANE8_WR: begin
                dec.wr = 1'b1;
                dec.xfer42 = 1'b1;
                dec.pso = 1'b1;
            end
            srb_pkg::OP_LANE8_RD: begin
                dec.rd = 1'b1;
                dec.xfer42 = 1'b1;
                dec.pso = 1'b1;
            end
            default: dec.rsvd = 1'b1;
        endcase
        // a sender that breaks the atomic restrictions still gets a scalar access
        if (dec.atom) begin
            dec.il = 1'b0;
            dec.pso = 1'b0;
        end
    end
endmodule // srb_decode

/* logic/srb_msg_unit.sv */
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - buffer entries are rows of 256 bits, accessed row by row
// - low 8 execution mask bits select stored or returned dwords per phase
// - atomics ignore the execution mask and always act as one scalar
// - out-of-region reads return zero data
// - out-of-region writes are dropped, buffer unchanged
// - per-slot offset bit adds slot offset to global offset, else slot offset ignored
// - interleave off uses handle 0; on, dwords 7:4 go to handle 1, 3:0 to handle 0
// - interleaved mode applies the same global offset to both entries
// - global offset is 11 bits, in row, half-row or dword units by message kind
// - opcode decode 0..8, codes 9 to 15 are reserved
// - writes carry data and get no writeback; reads carry no data (four-by-two reads only an offset phase) and are always answered
// - four-by-two transfers carry one offset phase, then write data for writes
// - non-interleaved half-row messages use low or high half by header bit 16
// - header channel mask bits are ANDed with channel enables per dword
// - mask bit 15 gates vertex 1 dword 3 interleaved, vertex 0 dword 7 otherwise
// - header bits 7:0 enable an outside-factor cull test; a hit notifies the hull stage
// - only the region limit register and the status drop count are kept between messages; each message carries all else it needs
// - handles come from header dwords 0 and 1; handle 1 only used interleaved
module srb_msg_unit #(
    parameter int DEPTH = srb_pkg::DEF_ROWS,
    parameter int AW = $clog2(srb_pkg::DEF_ROWS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic msg_valid,
    output logic msg_ready,
    input wire srb_pkg::srb_msg_t msg,
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic [srb_pkg::ROW_BITS-1:0] pay_data,
    output logic wb_valid,
    output logic [srb_pkg::ROW_BITS-1:0] wb_data,
    output logic wb_last,
    output logic cull_valid,
    output logic [srb_pkg::HANDLE_W-1:0] cull_handle
);
    typedef enum logic [3:0] {S_IDLE, S_OFFS, S_PAY, S_WR, S_RD, S_RDW, S_ATP, S_ATR, S_ATW} srb_state_t;

    srb_state_t state_q, state_d;
    logic [2:0] phase_q, phase_d;
    logic sub_q, sub_d;
    srb_pkg::srb_msg_t msg_q, msg_d;
    logic [31:0] so0_q, so0_d, so1_q, so1_d;
    logic [255:0] pay_q, pay_d, acc_q, acc_d;
    logic cull_q, cull_d;
    logic wb_valid_q, wb_valid_d, wb_last_q, wb_last_d;
    logic [255:0] wb_data_q, wb_data_d;
    logic cull_valid_q, cull_valid_d;
    logic [srb_pkg::HANDLE_W-1:0] cull_handle_q, cull_handle_d;
    logic [15:0] drop_q, drop_d;
    logic [31:0] region_q, region_d, prdata_q, prdata_d;

    srb_pkg::srb_dec_t dec;
    logic [srb_pkg::HANDLE_W-1:0] hsel;
    logic [31:0] off, half_row_unit_idx, row_off, row;
    logic full, oob, dest_hi, src_hi, last, cull_hit;
    logic [7:0] chan_en, we4;
    logic [3:0] en4;
    logic [127:0] src_half, rd_half;
    logic [255:0] rd_word;
    logic [31:0] old_word, new_word;
    logic [2:0] alane;
    logic [7:0] mem_we;
    logic mem_re;
    logic [255:0] mem_wdata, mem_rdata;

    // the idle state looks at the offered message, all others at the held one
    srb_decode u_dec (
        .desc(state_q == S_IDLE ? msg.desc : msg_q.desc),
        .dec(dec)
    );

    srb_row_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .pclk(pclk),
        .we(mem_we),
        .re(mem_re),
        .addr(row[AW-1:0]),
        .wdata(mem_wdata),
        .rdata_q(mem_rdata)
    );

    // address path, recomputed from held state so issue and capture cycles agree
    always_comb begin
        hsel = sub_q ? msg_q.handle1 : msg_q.handle0;
        off = {21'h0, dec.goff} + (dec.pso ? (sub_q ? so1_q : so0_q) : 32'h0);
        full = !dec.half && !dec.il;
        half_row_unit_idx = dec.half ? off + {29'h0, phase_q} : (off << 1) + {29'h0, phase_q};
        if (dec.atom) begin
            row_off = off >> 3;
        end else if (full) begin
            row_off = off + {29'h0, phase_q};
        end else begin
            row_off = half_row_unit_idx >> 1;
        end
        row = {17'h0, hsel, 1'b0} + row_off;
        // summed offsets past the sender's range are only kept safe, not meaningful
        oob = (row >= region_q) || (row >= DEPTH);
        dest_hi = half_row_unit_idx[0];
        src_hi = dec.il ? sub_q : msg_q.ctl[srb_pkg::HDR_HALF_BIT];
        chan_en = msg_q.exec_mask & msg_q.ctl[srb_pkg::HDR_CHMASK_LSB +: srb_pkg::LANES];
        en4 = src_hi ? chan_en[7:4] : chan_en[3:0];
        we4 = dest_hi ? {en4, 4'h0} : {4'h0, en4};
        src_half = src_hi ? pay_q[255:128] : pay_q[127:0];
        rd_half = dest_hi ? mem_rdata[255:128] : mem_rdata[127:0];
        rd_word = full ? mem_rdata : {2{rd_half}};
        last = ({1'b0, phase_q} + 4'h1) >= msg_q.phases;
        alane = off[2:0];
        old_word = oob ? 32'h0 : mem_rdata[32*alane +: 32];
        case (dec.aop)
            srb_pkg::AOP_MOV: new_word = pay_q[31:0];
            srb_pkg::AOP_INC: new_word = old_word + 32'h1;
            default: new_word = old_word + pay_q[31:0];
        endcase
        cull_hit = 1'b0;
        for (int j = 0; j < srb_pkg::LANES; j++) begin
            // factor at or below zero means the patch is culled
            if (msg_q.ctl[srb_pkg::HDR_CULL_LSB + j] && (pay_data[32*j+31] || pay_data[32*j +: 31] == 31'h0)) begin
                cull_hit = 1'b1;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        sub_d = sub_q;
        msg_d = msg_q;
        so0_d = so0_q;
        so1_d = so1_q;
        pay_d = pay_q;
        acc_d = acc_q;
        cull_d = cull_q;
        wb_valid_d = 1'b0;
        wb_last_d = 1'b0;
        wb_data_d = wb_data_q;
        cull_valid_d = 1'b0;
        cull_handle_d = cull_handle_q;
        drop_d = drop_q;
        mem_we = '0;
        mem_re = 1'b0;
        mem_wdata = full ? pay_q : {2{src_half}};
        msg_ready = (state_q == S_IDLE);
        pay_ready = (state_q == S_OFFS) || (state_q == S_PAY) || (state_q == S_ATP);
        case (state_q)
            S_IDLE: begin
                if (msg_valid) begin
                    // everything the operation needs is captured from this message
                    msg_d = msg;
                    so0_d = msg.slot0_off;
                    so1_d = msg.slot1_off;
                    phase_d = 3'h0;
                    sub_d = 1'b0;
                    acc_d = '0;
                    cull_d = 1'b0;
                    if (dec.rsvd) begin
                        state_d = S_IDLE;
                    end else if (dec.xfer42) begin
                        state_d = S_OFFS;
                    end else if (dec.atom) begin
                        state_d = (dec.aop == srb_pkg::AOP_INC) ? S_ATR : S_ATP;
                    end else begin
                        state_d = dec.wr ? S_PAY : S_RD;
                    end
                end
            end
            S_OFFS: begin
                if (pay_valid) begin
                    so0_d = pay_data[32*srb_pkg::SLOT0_LANE +: 32];
                    so1_d = pay_data[32*srb_pkg::SLOT1_LANE +: 32];
                    state_d = dec.wr ? S_PAY : S_RD;
                end
            end
            S_PAY: begin
                if (pay_valid) begin
                    pay_d = pay_data;
                    cull_d = cull_q | cull_hit;
                    state_d = S_WR;
                end
            end
            S_WR: begin
                if (!oob) begin
                    mem_we = full ? chan_en : we4;
                end else begin
                    drop_d = drop_q + 16'h1;
                end
                if (dec.il && !sub_q) begin
                    sub_d = 1'b1;
                end else begin
                    sub_d = 1'b0;
                    phase_d = phase_q + 3'h1;
                    if (last) begin
                        state_d = S_IDLE;
                        cull_valid_d = cull_q;
                        cull_handle_d = msg_q.handle0;
                    end else begin
                        state_d = S_PAY;
                    end
                end
            end
            S_RD: begin
                mem_re = !oob;
                state_d = S_RDW;
            end
            S_RDW: begin
                for (int j = 0; j < srb_pkg::LANES; j++) begin
                    if (full || ((j >= 4) == src_hi)) begin
                        acc_d[32*j +: 32] = (chan_en[j] && !oob) ? rd_word[32*j +: 32] : 32'h0;
                    end
                end
                if (dec.il && !sub_q) begin
                    sub_d = 1'b1;
                    state_d = S_RD;
                end else begin
                    wb_valid_d = 1'b1;
                    wb_data_d = acc_d;
                    wb_last_d = last;
                    acc_d = '0;
                    sub_d = 1'b0;
                    phase_d = phase_q + 3'h1;
                    state_d = last ? S_IDLE : S_RD;
                end
            end
            S_ATP: begin
                if (pay_valid) begin
                    pay_d = pay_data;
                    state_d = S_ATR;
                end
            end
            S_ATR: begin
                mem_re = !oob;
                state_d = S_ATW;
            end
            S_ATW: begin
                mem_wdata = {8{new_word}};
                if (!oob) begin
                    mem_we = 8'h01 << alane;
                end else begin
                    drop_d = drop_q + 16'h1;
                end
                wb_valid_d = 1'b1;
                wb_data_d = {224'h0, old_word};
                wb_last_d = 1'b1;
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            phase_q <= 3'h0;
            sub_q <= 1'b0;
            msg_q <= '0;
            so0_q <= 32'h0;
            so1_q <= 32'h0;
            pay_q <= '0;
            acc_q <= '0;
            cull_q <= 1'b0;
            wb_valid_q <= 1'b0;
            wb_last_q <= 1'b0;
            wb_data_q <= '0;
            cull_valid_q <= 1'b0;
            cull_handle_q <= '0;
            drop_q <= 16'h0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            sub_q <= sub_d;
            msg_q <= msg_d;
            so0_q <= so0_d;
            so1_q <= so1_d;
            pay_q <= pay_d;
            acc_q <= acc_d;
            cull_q <= cull_d;
            wb_valid_q <= wb_valid_d;
            wb_last_q <= wb_last_d;
            wb_data_q <= wb_data_d;
            cull_valid_q <= cull_valid_d;
            cull_handle_q <= cull_handle_d;
            drop_q <= drop_d;
        end
    end

    // register slave: zero wait states, read data prepared in the setup cycle
    always_comb begin
        region_d = region_q;
        prdata_d = prdata_q;
        if (psel && penable && pwrite && paddr == srb_pkg::REG_REGION) begin
            region_d = pwdata;
        end
        if (psel && !penable) begin
            if (paddr == srb_pkg::REG_REGION) begin
                prdata_d = region_q;
            end else if (paddr == srb_pkg::REG_STATUS) begin
                prdata_d = {drop_q, 15'h0, state_q != S_IDLE};
            end else begin
                prdata_d = 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            region_q <= srb_pkg::REGION_RST;
            prdata_q <= 32'h0;
        end else begin
            region_q <= region_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr != srb_pkg::REG_REGION) && (paddr != srb_pkg::REG_STATUS);
    assign wb_valid = wb_valid_q;
    assign wb_data = wb_data_q;
    assign wb_last = wb_last_q;
    assign cull_valid = cull_valid_q;
    assign cull_handle = cull_handle_q;

    property p_oob_write;
        @(posedge pclk) disable iff (!presetn) oob |-> mem_we == 8'h00;
    endproperty
    a_oob_write: assert property (p_oob_write) else $error("write reached memory outside region");

    property p_oob_read;
        @(posedge pclk) disable iff (!presetn) (state_q == S_RDW && oob && full) |=> wb_valid_q && wb_data_q == '0;
    endproperty
    a_oob_read: assert property (p_oob_read) else $error("out of region read not zero");

    property p_atom_enabled;
        @(posedge pclk) disable iff (!presetn) (state_q == S_ATW && !oob) |-> $onehot(mem_we);
    endproperty
    a_atom_enabled: assert property (p_atom_enabled) else $error("atomic not performed");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn) (state_q == S_IDLE && msg_valid && dec.rsvd) |=> state_q == S_IDLE && !wb_valid_q;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved opcode acted");

    property p_lane_mask;
        @(posedge pclk) disable iff (!presetn) (state_q == S_WR) |-> (mem_we & ~(full ? chan_en : we4)) == 8'h00;
    endproperty
    a_lane_mask: assert property (p_lane_mask) else $error("masked lane written");

    property p_read_answer;
        @(posedge pclk) disable iff (!presetn) (state_q == S_RD && !sub_q) |-> ##[2:4] wb_valid_q;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read phase without writeback");

    property p_write_silent;
        @(posedge pclk) disable iff (!presetn) (state_q == S_WR) |=> !wb_valid_q;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("writeback during write");

    property p_single_entry;
        @(posedge pclk) disable iff (!presetn) (state_q != S_IDLE && !dec.il) |-> !sub_q;
    endproperty
    a_single_entry: assert property (p_single_entry) else $error("handle 1 used without interleave");

    property p_cull;
        @(posedge pclk) disable iff (!presetn) cull_valid_q |-> $past(state_q) == S_WR && $past(cull_q);
    endproperty
    a_cull: assert property (p_cull) else $error("cull notice without hit");
endmodule // srb_msg_unit

/* logic/srb_pkg.sv */
package srb_pkg;
    localparam int DESC_W = 20;
    localparam int DESC_PSO_BIT = 17;
    localparam int DESC_IL_BIT = 15;
    localparam int DESC_GOFF_LSB = 4;
    localparam int GOFF_W = 11;
    localparam int OP_W = 4;
    localparam int HANDLE_W = 14;
    localparam int HDR_HALF_BIT = 16;
    localparam int HDR_CHMASK_LSB = 8;
    localparam int HDR_CULL_LSB = 0;
    localparam int LANES = 8;
    localparam int ROW_BITS = 256;
    localparam int SLOT0_LANE = 3;
    localparam int SLOT1_LANE = 4;
    localparam int DEF_ROWS = 1024;

    localparam logic [3:0] OP_ROW_WR = 4'h0;
    localparam logic [3:0] OP_HALF_WR = 4'h1;
    localparam logic [3:0] OP_ROW_RD = 4'h2;
    localparam logic [3:0] OP_HALF_RD = 4'h3;
    localparam logic [3:0] OP_ATOM_MOV = 4'h4;
    localparam logic [3:0] OP_ATOM_INC = 4'h5;
    localparam logic [3:0] OP_ATOM_ADD = 4'h6;
    localparam logic [3:0] OP_LANE8_WR = 4'h7;
    localparam logic [3:0] OP_LANE8_RD = 4'h8;

    localparam logic [1:0] AOP_MOV = 2'h0;
    localparam logic [1:0] AOP_INC = 2'h1;
    localparam logic [1:0] AOP_ADD = 2'h2;

    localparam logic [7:0] REG_REGION = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [31:0] REGION_RST = 32'h0000_0400;

    typedef struct packed {
        logic [DESC_W-1:0] desc;
        logic [HANDLE_W-1:0] handle0;
        logic [HANDLE_W-1:0] handle1;
        logic [31:0] slot0_off;
        logic [31:0] slot1_off;
        logic [31:0] ctl;
        logic [LANES-1:0] exec_mask;
        logic [3:0] phases;
    } srb_msg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic atom;
        logic half;
        logic il;
        logic pso;
        logic xfer42;
        logic rsvd;
        logic [1:0] aop;
        logic [GOFF_W-1:0] goff;
    } srb_dec_t;
endpackage

/* logic/srb_row_mem.sv */
`timescale 1ns/10ps
module srb_row_mem #(
    parameter int DEPTH = srb_pkg::DEF_ROWS,
    parameter int AW = 10
) (
    input wire logic pclk,
    input wire logic [srb_pkg::LANES-1:0] we,
    input wire logic re,
    input wire logic [AW-1:0] addr,
    input wire logic [srb_pkg::ROW_BITS-1:0] wdata,
    output logic [srb_pkg::ROW_BITS-1:0] rdata_q
);
    genvar g;
    // one dword-wide array per lane so lane enables need no read-modify-write
    for (g = 0; g < srb_pkg::LANES; g++) begin : g_lane
        logic [31:0] ram [DEPTH];
        always_ff @(posedge pclk) begin
            if (we[g]) begin
                ram[addr] <= wdata[32*g +: 32];
            end
            if (re) begin
                rdata_q[32*g +: 32] <= ram[addr];
            end
        end
    end
endmodule // srb_row_mem

/* verification/srb_eu_model.sv */
`timescale 1ns/10ps
module srb_eu_model (
    input wire logic pclk,
    input wire logic msg_ready,
    input wire logic pay_ready,
    output logic msg_valid,
    output srb_pkg::srb_msg_t msg,
    output logic pay_valid,
    output logic [srb_pkg::ROW_BITS-1:0] pay_data
);
    initial begin
        msg_valid = 1'b0;
        pay_valid = 1'b0;
        msg = '0;
        pay_data = '0;
    end
    // no end-of-thread flag is carried, so reads and atomics never raise one
    task automatic send(input srb_pkg::srb_msg_t m);
        m.desc[19] = 1'b1;
        if (m.desc[3:0] inside {4'h4, 4'h5, 4'h6}) begin
            m.desc[17] = 1'b0;
            m.desc[15] = 1'b0;
        end
        msg_valid <= 1'b1;
        msg <= m;
        do @(negedge pclk); while (msg_ready !== 1'b1);
        @(posedge pclk);
        msg_valid <= 1'b0;
        // inverse, not a stale copy, once released
        msg <= ~m;
    endtask
    // offset phase first, then write data; reads carry offsets only
    task automatic push(input logic [srb_pkg::ROW_BITS-1:0] d, input logic last);
        pay_valid <= 1'b1;
        pay_data <= d;
        do @(negedge pclk); while (pay_ready !== 1'b1);
        @(posedge pclk);
        if (last) begin
            pay_valid <= 1'b0;
            pay_data <= ~d;
        end
    endtask
endmodule // srb_eu_model

/* verification/tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic msg_valid, msg_ready, pay_valid, pay_ready, wb_valid, wb_last, cull_valid;
    logic [255:0] pay_data, wb_data, a, b, x, sl;
    logic [13:0] cull_handle, ch;
    srb_pkg::srb_msg_t msg;
    logic [255:0] wbq[$];
    int fail_count, compares, lasts, culls;
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    srb_msg_unit #(.DEPTH(64), .AW(6)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg), .pay_valid(pay_valid), .pay_ready(pay_ready),
        .pay_data(pay_data), .wb_valid(wb_valid), .wb_data(wb_data), .wb_last(wb_last), .cull_valid(cull_valid),
        .cull_handle(cull_handle));
    srb_eu_model eu (.pclk(pclk), .msg_ready(msg_ready), .pay_ready(pay_ready), .msg_valid(msg_valid),
        .msg(msg), .pay_valid(pay_valid), .pay_data(pay_data));
    always @(posedge pclk) begin
        if (wb_valid === 1'b1) begin
            wbq.push_back(wb_data);
            lasts += (wb_last === 1'b1);
        end
        if (cull_valid === 1'b1) begin
            culls++;
            ch = cull_handle;
        end
    end
    function automatic logic [255:0] pat(input logic [23:0] s);
        for (int j = 0; j < 8; j++) begin
            pat[32*j +: 32] = {s, 8'(j)};
        end
    endfunction
    function automatic srb_pkg::srb_msg_t mk(input logic [3:0] op, input logic [10:0] g, input logic [13:0] h,
        input logic [31:0] c, input logic [7:0] em = 8'hff, input logic ps = 1'b0, input logic il = 1'b0);
        mk = '0;
        mk.desc = {2'b00, ps, 1'b0, il, g, op}; // callers keep global offsets in range
        mk.handle0 = h;
        mk.handle1 = h + 14'd1;
        mk.slot0_off = 32'h1;
        mk.slot1_off = 32'h1;
        mk.ctl = c;
        mk.exec_mask = em;
        mk.phases = 4'h1;
    endfunction
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this time step
        @(posedge pclk);
    endtask
    task automatic xfer(input srb_pkg::srb_msg_t m, input logic p = 1'b0, input logic [255:0] d = '0,
        input int n = 0, input logic [255:0] e = '0);
        wbq.delete();
        lasts = 0;
        eu.send(m);
        if (m.desc[3:0] inside {4'h7, 4'h8}) eu.push(sl, !p);
        if (p) eu.push(d, 1'b1);
        do @(negedge pclk); while (msg_ready !== 1'b1);
        repeat (4) @(posedge pclk);
        `CHK("wb count", n, wbq.size())
        `CHK("wb last", n, lasts)
        if (n > 0) `CHK("wb data", e, wbq[0])
    endtask
    task automatic results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        $display("FAIL watchdog");
        results();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        culls = 0;
        sl = (256'h1 << 96) | (256'h1 << 128);
        a = pat(24'haaaa00);
        b = pat(24'hbbbb00);
        repeat (8) @(posedge pclk);
        `CHK("msg_ready", 1'b1, msg_ready)
        `CHK("pay_ready", 1'b0, pay_ready)
        `CHK("wb_valid", 1'b0, wb_valid)
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("region", 32'h0000_0400, rd)
        apb(1'b1, 8'h00, 32'h0000_0020);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("region", 32'h0000_0020, rd)
        apb(1'b0, 8'h08, 32'h0);
        `CHK("slverr", 1'b1, err)
        $display("test registers done");
        xfer(mk(srb_pkg::OP_ROW_WR, 11'd1, 14'd2, 32'h0000_ff01), 1'b1, a);
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd1, 14'd2, 32'h0000_ff00), , , 1, a);
        xfer(mk(srb_pkg::OP_ROW_WR, 11'd1, 14'd2, 32'h0000_ff00, 8'h0f), 1'b1, b);
        x = {32'h0, a[223:128], b[127:0]};
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd1, 14'd2, 32'h0000_7f00), , , 1, x);
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd0, 14'd2, 32'h0000_7f00, 8'hff, 1'b1), , , 1, x);
        $display("test row access done");
        xfer(mk(srb_pkg::OP_ROW_WR, 11'd0, 14'd20, 32'h0000_ff00), 1'b1, b);
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd0, 14'd20, 32'h0000_ff00), , , 1, '0);
        apb(1'b0, 8'h04, 32'h0);
        `CHK("status", 32'h0001_0000, rd)
        $display("test bounds done");
        x[95:64] = b[95:64] + 32'h1;
        xfer(mk(srb_pkg::OP_ATOM_INC, 11'd10, 14'd2, 32'h0, 8'h00), , , 1, {224'h0, b[95:64]});
        xfer(mk(srb_pkg::OP_ATOM_ADD, 11'd10, 14'd2, 32'h0, 8'h00), 1'b1, 256'h3, 1, {224'h0, x[95:64]});
        x[95:64] = x[95:64] + 32'h3;
        xfer(mk(srb_pkg::OP_ATOM_MOV, 11'd10, 14'd2, 32'h0, 8'h00), 1'b1, 256'h9, 1, {224'h0, x[95:64]});
        x[95:64] = 32'h9;
        for (int c = 9; c < 16; c++) begin
            xfer(mk(4'(c), 11'd1, 14'd2, 32'h0000_ff00));
        end
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd1, 14'd2, 32'h0000_7f00), , , 1, x);
        $display("test atomics and reserved done");
        xfer(mk(srb_pkg::OP_LANE8_WR, 11'd0, 14'd3, 32'h0000_ff00), 1'b1, a);
        xfer(mk(srb_pkg::OP_LANE8_RD, 11'd0, 14'd3, 32'h0000_ff00), , , 1, a);
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd1, 14'd2, 32'h0000_ff00, 8'hff, 1'b0, 1'b1), , , 1,
            {a[127:0], x[127:0]});
        xfer(mk(srb_pkg::OP_HALF_WR, 11'd3, 14'd3, 32'h0001_ff00), 1'b1, b);
        xfer(mk(srb_pkg::OP_HALF_RD, 11'd3, 14'd3, 32'h0000_ff00), , , 1, {128'h0, b[255:128]});
        xfer(mk(srb_pkg::OP_ROW_RD, 11'd1, 14'd3, 32'h0000_ff00), , , 1, {b[255:128], a[127:0]});
        `CHK("culls", 1, culls)
        `CHK("cull handle", 14'd2, ch)
        $display("test lanes and interleave done");
        results();
    end
endmodule // tb_top
